// [design/umsd_pkg.sv]
package umsd_pkg;

    // unified map, 16-bit addresses
    localparam logic [15:0] FLASH_BASE = 16'h0000;
    localparam logic [15:0] FLASH_TOP_8K = 16'h1FFF;
    localparam logic [15:0] FLASH_TOP_16K = 16'h3FFF;
    localparam logic [15:0] FLASH_TOP_32K = 16'h7FFF;
    localparam logic [15:0] SRAM_BASE = 16'hF000;
    localparam logic [15:0] SRAM_TOP_1K = 16'hF2FF;
    localparam logic [15:0] SRAM_TOP_2K = 16'hF6FF;
    localparam logic [15:0] SRAM_TOP_4K = 16'hFEFF;
    localparam logic [15:0] NONRET_LO = 16'hFDA2;
    localparam logic [15:0] NONRET_HI = 16'hFEFF;
    localparam logic [15:0] IDATA_BASE = 16'hFF00;
    localparam logic [15:0] RADIO_LO = 16'hDF00;
    localparam logic [15:0] RADIO_HI = 16'hDF3D;
    localparam logic [15:0] I2S_LO = 16'hDF40;
    localparam logic [15:0] I2S_HI = 16'hDF48;
    localparam logic [15:0] SFR_LO = 16'hDF80;
    localparam logic [15:0] SFR_HI = 16'hDFFF;
    localparam logic [15:0] USB_LO = 16'hDE00;
    localparam logic [15:0] USB_HI = 16'hDE3F;

    // flash size variants in KB
    localparam int FLASH_KB_8 = 8;
    localparam int FLASH_KB_16 = 16;
    localparam int FLASH_KB_32 = 32;

    // direct data space and special function register space
    localparam logic [7:0] DATA_UPPER_BASE = 8'h80;
    localparam int SFR_ADDR_W = 7;
    localparam int SFR_SPAN = 128;
    localparam int SFR_ALIGN_BITS = 3;
    localparam logic [SFR_ALIGN_BITS-1:0] SFR_ALIGN_ZERO = 3'h0;
    // registers kept inside the core, reachable only through the register space
    localparam logic [SFR_SPAN-1:0] CORE_SFR_MASK_DEFAULT = 128'h00010001_00010000_00000100_000400BE;

    // value handed back for an access that hits no target
    localparam logic [7:0] DATA_UNMAPPED = 8'h00;

    // bus occupancy in clocks
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] INSN_BUS_CYCLES = 3'h1;
    localparam logic [CNT_W-1:0] XDATA_BUS_CYCLES = 3'h4;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

    // target select positions
    localparam int TGT_FLASH = 0;
    localparam int TGT_SRAM = 1;
    localparam int TGT_IDATA = 2;
    localparam int TGT_RADIO = 3;
    localparam int TGT_I2S = 4;
    localparam int TGT_SFR = 5;
    localparam int TGT_USB = 6;
    localparam int TGT_COUNT = 7;

    typedef logic [TGT_COUNT-1:0] umsd_sel_type;
    typedef enum {UMSD_SRC_NONE, UMSD_SRC_FETCH, UMSD_SRC_XDATA, UMSD_SRC_DMA} umsd_src_type;
    typedef enum {BUS_IDLE, BUS_ACTIVE} umsd_bus_type;

endpackage

// [design/umsd_dec_if.sv]
`timescale 1ns/1ns
interface umsd_dec_if import umsd_pkg::*; ();
    logic [15:0] addr;
    logic wr;
    umsd_sel_type sel;
    logic [15:0] offset;
    logic nonret;

    modport decoder (input addr, input wr, output sel, output offset, output nonret);
    modport user (output addr, output wr, input sel, input offset, input nonret);
endinterface

// [design/umsd_region_decode.sv]
`timescale 1ns/1ns
module umsd_region_decode import umsd_pkg::*; #(
    parameter logic [15:0] FLASH_TOP = FLASH_TOP_32K,
    parameter logic [15:0] SRAM_TOP = SRAM_TOP_4K,
    parameter bit HAS_USB = 1'b1,
    parameter bit HAS_NONRET = 1'b1,
    parameter logic [SFR_SPAN-1:0] CORE_SFR_MASK = CORE_SFR_MASK_DEFAULT
) (
    umsd_dec_if.decoder dec
);

    always_comb begin
        dec.sel = '0;
        dec.offset = '0;
        dec.nonret = 1'b0;
        if (dec.addr <= FLASH_TOP) begin
            // flash is never written through the map
            if (!dec.wr) begin
                dec.sel[TGT_FLASH] = 1'b1;
                dec.offset = dec.addr - FLASH_BASE;
            end
        end else if (dec.addr >= IDATA_BASE) begin
            dec.sel[TGT_IDATA] = 1'b1;
            dec.offset = dec.addr - IDATA_BASE;
        end else if (dec.addr >= SRAM_BASE && dec.addr <= SRAM_TOP) begin
            dec.sel[TGT_SRAM] = 1'b1;
            dec.offset = dec.addr - SRAM_BASE;
            dec.nonret = HAS_NONRET && dec.addr >= NONRET_LO && dec.addr <= NONRET_HI;
        end else if (dec.addr >= RADIO_LO && dec.addr <= RADIO_HI) begin
            dec.sel[TGT_RADIO] = 1'b1;
            dec.offset = dec.addr - RADIO_LO;
        end else if (dec.addr >= I2S_LO && dec.addr <= I2S_HI) begin
            dec.sel[TGT_I2S] = 1'b1;
            dec.offset = dec.addr - I2S_LO;
        end else if (dec.addr >= SFR_LO && dec.addr <= SFR_HI) begin
            // core-internal registers are not mirrored into the map
            if (!CORE_SFR_MASK[dec.addr[SFR_ADDR_W-1:0]]) begin
                dec.sel[TGT_SFR] = 1'b1;
                dec.offset = dec.addr - SFR_LO;
            end
        end else if (HAS_USB && dec.addr >= USB_LO && dec.addr <= USB_HI) begin
            dec.sel[TGT_USB] = 1'b1;
            dec.offset = dec.addr - USB_LO;
        end
        // anything else selects nothing
    end

endmodule // umsd_region_decode

// [design/umsd_decoder.sv]
`timescale 1ns/1ns
// Summary of operation
// - addresses from zero to the flash top go to flash, per size variant.
// - on-chip SRAM starts at 0xF000, sized 1, 2 or 4 KB.
// - on 32 KB parts 0xFDA2-0xFEFF is flagged as lost in deep power modes.
// - 0xFF00-0xFFFF reaches the same bytes as the indirect data space.
// - 0xDF00-0xDF3D goes to the radio register file.
// - 0xDF40-0xDF48 goes to the I2S registers.
// - 0xDF80-0xDFFF mirrors special registers, except core-internal ones.
// - 0xDE00-0xDE3F reaches USB registers only on the USB variant.
// - instruction fetch decodes exactly like data accesses, so SRAM can run code.
// - data writes work over the whole map but never alter flash.
// - lower 128 data bytes take direct and indirect access, upper only indirect.
// - special register space uses 7-bit address; multiples of eight are bit-addressable.
// - fetch and external data share one bus; fetch stalls during data access.
// - one clock per instruction cycle instead of twelve.
// - the DMA controller reaches every region through the unified map.
// - code space is a 16-bit read-only program memory space.
module umsd_decoder import umsd_pkg::*; #(
    parameter int FLASH_KB = FLASH_KB_32,
    parameter bit HAS_USB = 1'b1,
    parameter logic [SFR_SPAN-1:0] CORE_SFR_MASK = CORE_SFR_MASK_DEFAULT
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic fetch_req,
    input wire logic [15:0] fetch_addr,
    output logic fetch_ack,
    output logic [7:0] fetch_rdata,
    output logic fetch_stall,
    input wire logic xd_req,
    input wire logic [15:0] xd_addr,
    input wire logic xd_wr,
    input wire logic [7:0] xd_wdata,
    output logic xd_ack,
    output logic [7:0] xd_rdata,
    input wire logic dma_req,
    input wire logic [15:0] dma_addr,
    input wire logic dma_wr,
    input wire logic [7:0] dma_wdata,
    output logic dma_ack,
    output logic [7:0] dma_rdata,
    output logic [TGT_COUNT-1:0] tgt_sel,
    output logic [15:0] tgt_offset,
    output logic [SFR_ADDR_W-1:0] tgt_sfr_addr,
    output logic tgt_wr,
    output logic [7:0] tgt_wdata,
    input wire logic [7:0] tgt_rdata,
    output logic tgt_nonret,
    output logic tgt_unmapped,
    input wire logic dd_req,
    input wire logic [7:0] dd_addr,
    input wire logic dd_indirect,
    input wire logic dd_bit,
    output logic dd_ack,
    output logic dd_idata_sel,
    output logic dd_sfr_sel,
    output logic dd_sfr_bitok,
    output logic dd_refused,
    output logic [7:0] dd_index
);

    localparam logic [15:0] FLASH_TOP = (FLASH_KB == FLASH_KB_8) ? FLASH_TOP_8K :
                                        (FLASH_KB == FLASH_KB_16) ? FLASH_TOP_16K : FLASH_TOP_32K;
    localparam logic [15:0] SRAM_TOP = (FLASH_KB == FLASH_KB_8) ? SRAM_TOP_1K :
                                       (FLASH_KB == FLASH_KB_16) ? SRAM_TOP_2K : SRAM_TOP_4K;
    localparam bit HAS_NONRET = (FLASH_KB == FLASH_KB_32);

    umsd_bus_type state_reg;
    umsd_src_type src_reg;
    umsd_src_type win_src;
    logic [CNT_W-1:0] cnt_reg;
    logic [15:0] win_addr;
    logic win_wr;
    logic [7:0] win_wdata;
    logic grant;
    logic done;
    logic fetch_ack_reg, xd_ack_reg, dma_ack_reg;
    logic [7:0] fetch_rdata_reg, xd_rdata_reg, dma_rdata_reg;
    logic fetch_stall_reg;
    umsd_sel_type tgt_sel_reg;
    logic [15:0] tgt_offset_reg;
    logic [SFR_ADDR_W-1:0] tgt_sfr_addr_reg;
    logic tgt_wr_reg, tgt_nonret_reg, tgt_unmapped_reg;
    logic [7:0] tgt_wdata_reg;
    logic dd_ack_reg, dd_idata_sel_reg, dd_sfr_sel_reg, dd_sfr_bitok_reg, dd_refused_reg;
    logic [7:0] dd_index_reg;
    logic dd_aligned;

    // one shared bus: data access wins over DMA, DMA over fetch
    always_comb begin
        win_src = UMSD_SRC_NONE;
        win_addr = '0;
        win_wr = 1'b0;
        win_wdata = '0;
        if (xd_req && !xd_ack_reg) begin
            win_src = UMSD_SRC_XDATA;
            win_addr = xd_addr;
            win_wr = xd_wr;
            win_wdata = xd_wdata;
        end else if (dma_req && !dma_ack_reg) begin
            win_src = UMSD_SRC_DMA;
            win_addr = dma_addr;
            win_wr = dma_wr;
            win_wdata = dma_wdata;
        end else if (fetch_req && !fetch_ack_reg) begin
            // code space is read-only
            win_src = UMSD_SRC_FETCH;
            win_addr = fetch_addr;
        end
    end

    assign grant = (state_reg == BUS_IDLE) && (win_src != UMSD_SRC_NONE);
    assign done = (state_reg == BUS_ACTIVE) && (cnt_reg == CNT_ONE);

    // all masters share the one decoder, so fetch and data maps cannot drift apart
    umsd_dec_if dec_bus ();
    assign dec_bus.addr = win_addr;
    assign dec_bus.wr = win_wr;

    umsd_region_decode #(
        .FLASH_TOP(FLASH_TOP),
        .SRAM_TOP(SRAM_TOP),
        .HAS_USB(HAS_USB),
        .HAS_NONRET(HAS_NONRET),
        .CORE_SFR_MASK(CORE_SFR_MASK)
    ) u_region_decode (
        .dec(dec_bus)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= BUS_IDLE;
            src_reg <= UMSD_SRC_NONE;
            cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                BUS_IDLE: begin
                    if (grant) begin
                        state_reg <= BUS_ACTIVE;
                        src_reg <= win_src;
                        // data access holds the bus longer; fetch takes one clock
                        cnt_reg <= (win_src == UMSD_SRC_XDATA) ? XDATA_BUS_CYCLES : INSN_BUS_CYCLES;
                    end
                end
                BUS_ACTIVE: begin
                    if (done) begin
                        state_reg <= BUS_IDLE;
                        src_reg <= UMSD_SRC_NONE;
                    end else begin
                        cnt_reg <= cnt_reg - CNT_ONE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || done) begin
            tgt_sel_reg <= '0;
            tgt_offset_reg <= '0;
            tgt_sfr_addr_reg <= '0;
            tgt_wr_reg <= 1'b0;
            tgt_wdata_reg <= '0;
            tgt_nonret_reg <= 1'b0;
            tgt_unmapped_reg <= 1'b0;
        end else if (grant) begin
            tgt_sel_reg <= dec_bus.sel;
            tgt_offset_reg <= dec_bus.offset;
            tgt_sfr_addr_reg <= win_addr[SFR_ADDR_W-1:0];
            tgt_wr_reg <= win_wr && (dec_bus.sel != '0);
            tgt_wdata_reg <= win_wdata;
            tgt_nonret_reg <= dec_bus.nonret;
            tgt_unmapped_reg <= (dec_bus.sel == '0);
        end
    end

    // unmapped reads return a fixed value; masters must not depend on it
    always_ff @(posedge mclk) begin
        if (reset) begin
            fetch_ack_reg <= 1'b0;
            xd_ack_reg <= 1'b0;
            dma_ack_reg <= 1'b0;
            fetch_rdata_reg <= '0;
            xd_rdata_reg <= '0;
            dma_rdata_reg <= '0;
        end else begin
            fetch_ack_reg <= done && (src_reg == UMSD_SRC_FETCH);
            xd_ack_reg <= done && (src_reg == UMSD_SRC_XDATA);
            dma_ack_reg <= done && (src_reg == UMSD_SRC_DMA);
            if (done) begin
                unique case (src_reg)
                    UMSD_SRC_FETCH: fetch_rdata_reg <= tgt_unmapped_reg ? DATA_UNMAPPED : tgt_rdata;
                    UMSD_SRC_XDATA: xd_rdata_reg <= tgt_unmapped_reg ? DATA_UNMAPPED : tgt_rdata;
                    UMSD_SRC_DMA: dma_rdata_reg <= tgt_unmapped_reg ? DATA_UNMAPPED : tgt_rdata;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            fetch_stall_reg <= 1'b0;
        end else begin
            fetch_stall_reg <= fetch_req && !fetch_ack_reg && ((grant && win_src == UMSD_SRC_XDATA) ||
                (state_reg == BUS_ACTIVE && src_reg == UMSD_SRC_XDATA && !done));
        end
    end

    // direct data path: one clock per access
    assign dd_aligned = (dd_addr[SFR_ALIGN_BITS-1:0] == SFR_ALIGN_ZERO);

    always_ff @(posedge mclk) begin
        if (reset) begin
            dd_ack_reg <= 1'b0;
            dd_idata_sel_reg <= 1'b0;
            dd_sfr_sel_reg <= 1'b0;
            dd_sfr_bitok_reg <= 1'b0;
            dd_refused_reg <= 1'b0;
            dd_index_reg <= '0;
        end else if (dd_req && !dd_ack_reg) begin
            dd_ack_reg <= 1'b1;
            dd_index_reg <= dd_addr;
            if (dd_addr < DATA_UPPER_BASE || dd_indirect) begin
                dd_idata_sel_reg <= 1'b1;
                dd_sfr_sel_reg <= 1'b0;
                dd_sfr_bitok_reg <= 1'b0;
                dd_refused_reg <= 1'b0;
            end else begin
                dd_idata_sel_reg <= 1'b0;
                dd_sfr_sel_reg <= 1'b1;
                dd_sfr_bitok_reg <= dd_aligned;
                dd_refused_reg <= dd_bit && !dd_aligned;
            end
        end else begin
            dd_ack_reg <= 1'b0;
            dd_idata_sel_reg <= 1'b0;
            dd_sfr_sel_reg <= 1'b0;
            dd_sfr_bitok_reg <= 1'b0;
            dd_refused_reg <= 1'b0;
        end
    end

    assign fetch_ack = fetch_ack_reg;
    assign fetch_rdata = fetch_rdata_reg;
    assign fetch_stall = fetch_stall_reg;
    assign xd_ack = xd_ack_reg;
    assign xd_rdata = xd_rdata_reg;
    assign dma_ack = dma_ack_reg;
    assign dma_rdata = dma_rdata_reg;
    assign tgt_sel = tgt_sel_reg;
    assign tgt_offset = tgt_offset_reg;
    assign tgt_sfr_addr = tgt_sfr_addr_reg;
    assign tgt_wr = tgt_wr_reg;
    assign tgt_wdata = tgt_wdata_reg;
    assign tgt_nonret = tgt_nonret_reg;
    assign tgt_unmapped = tgt_unmapped_reg;
    assign dd_ack = dd_ack_reg;
    assign dd_idata_sel = dd_idata_sel_reg;
    assign dd_sfr_sel = dd_sfr_sel_reg;
    assign dd_sfr_bitok = dd_sfr_bitok_reg;
    assign dd_refused = dd_refused_reg;
    assign dd_index = dd_index_reg;

    property p_flash_read;
        @(posedge mclk) disable iff (reset)
        (grant && !win_wr && win_addr <= FLASH_TOP) |=> tgt_sel[TGT_FLASH] && tgt_offset == $past(win_addr);
    endproperty
    a_flash_read: assert property (p_flash_read) else $error("flash read not routed to flash");

    property p_sram_route;
        @(posedge mclk) disable iff (reset)
        (grant && win_addr >= SRAM_BASE && win_addr <= SRAM_TOP) |=> tgt_sel[TGT_SRAM] && !tgt_unmapped;
    endproperty
    a_sram_route: assert property (p_sram_route) else $error("sram address not routed to sram");

    property p_nonret;
        @(posedge mclk) disable iff (reset)
        grant |=> tgt_nonret == (HAS_NONRET && $past(win_addr) >= NONRET_LO && $past(win_addr) <= NONRET_HI);
    endproperty
    a_nonret: assert property (p_nonret) else $error("non-retained flag wrong");

    property p_idata;
        @(posedge mclk) disable iff (reset)
        (grant && win_addr >= IDATA_BASE) |=> tgt_sel[TGT_IDATA] && tgt_offset[7:0] == $past(win_addr[7:0]);
    endproperty
    a_idata: assert property (p_idata) else $error("data window not mirrored");

    property p_radio;
        @(posedge mclk) disable iff (reset)
        (grant && win_addr >= RADIO_LO && win_addr <= RADIO_HI) |=> tgt_sel[TGT_RADIO];
    endproperty
    a_radio: assert property (p_radio) else $error("radio window not routed");

    property p_i2s;
        @(posedge mclk) disable iff (reset)
        (grant && win_addr >= I2S_LO && win_addr <= I2S_HI) |=> tgt_sel[TGT_I2S];
    endproperty
    a_i2s: assert property (p_i2s) else $error("i2s window not routed");

    property p_sfr_mirror;
        @(posedge mclk) disable iff (reset)
        (grant && win_addr >= SFR_LO) && (win_addr < IDATA_BASE && win_addr <= SFR_HI) |=>
            tgt_sel[TGT_SFR] == !CORE_SFR_MASK[$past(win_addr[SFR_ADDR_W-1:0])];
    endproperty
    a_sfr_mirror: assert property (p_sfr_mirror) else $error("register mirror wrong");

    property p_usb;
        @(posedge mclk) disable iff (reset)
        (grant && win_addr >= USB_LO && win_addr <= USB_HI) |=> tgt_sel[TGT_USB] == HAS_USB && tgt_unmapped == !HAS_USB;
    endproperty
    a_usb: assert property (p_usb) else $error("usb window wrong");

    property p_flash_nowrite;
        @(posedge mclk) disable iff (reset)
        (grant && win_wr && win_addr <= FLASH_TOP) |=> !tgt_sel[TGT_FLASH] && !tgt_wr;
    endproperty
    a_flash_nowrite: assert property (p_flash_nowrite) else $error("flash write reached flash");

    property p_upper_direct;
        @(posedge mclk) disable iff (reset)
        (dd_req && !dd_ack && !dd_indirect && dd_addr >= DATA_UPPER_BASE) |=> dd_sfr_sel && !dd_idata_sel;
    endproperty
    a_upper_direct: assert property (p_upper_direct) else $error("direct upper access hit data");

    property p_bit_align;
        @(posedge mclk) disable iff (reset)
        dd_sfr_sel |-> dd_sfr_bitok == (dd_index[SFR_ALIGN_BITS-1:0] == SFR_ALIGN_ZERO) && !(dd_refused && dd_sfr_bitok);
    endproperty
    a_bit_align: assert property (p_bit_align) else $error("bit access alignment wrong");

    property p_xdata_hold;
        @(posedge mclk) disable iff (reset)
        (grant && win_src == UMSD_SRC_XDATA) |=> !fetch_ack[*4] ##1 xd_ack;
    endproperty
    a_xdata_hold: assert property (p_xdata_hold) else $error("fetch passed during data access");

    property p_fetch_one_clock;
        @(posedge mclk) disable iff (reset)
        (grant && win_src == UMSD_SRC_FETCH) |-> ##2 fetch_ack;
    endproperty
    a_fetch_one_clock: assert property (p_fetch_one_clock) else $error("fetch took more than one clock");

    property p_onehot;
        @(posedge mclk) disable iff (reset)
        $onehot0(tgt_sel) && (tgt_unmapped -> tgt_sel == '0);
    endproperty
    a_onehot: assert property (p_onehot) else $error("more than one target selected");

    c_xdata: cover property (@(posedge mclk) disable iff (reset) xd_ack && $past(tgt_sel[TGT_SFR]));
    c_fetch_sram: cover property (@(posedge mclk) disable iff (reset)
        (grant && win_src == UMSD_SRC_FETCH) ##1 tgt_sel[TGT_SRAM]);
    c_dma_radio: cover property (@(posedge mclk) disable iff (reset)
        (grant && win_src == UMSD_SRC_DMA) ##1 tgt_sel[TGT_RADIO]);
    c_stall: cover property (@(posedge mclk) disable iff (reset) fetch_stall [*3]);

endmodule // umsd_decoder

// [tb/umsd_target_model.sv]
`timescale 1ns/1ns
module umsd_target_model import umsd_pkg::*; (
    input wire logic mclk,
    input wire logic [TGT_COUNT-1:0] tgt_sel,
    input wire logic [15:0] tgt_offset,
    output logic [7:0] tgt_rdata
);
    logic [7:0] churn_reg = 8'h00;
    always_ff @(posedge mclk) begin
        churn_reg <= churn_reg + 8'h5B;
    end
    // an unselected target releases the bus: show a moving pattern, never the last byte
    assign tgt_rdata = (tgt_sel != '0) ? (tgt_offset[7:0] ^ 8'hA5) : churn_reg;
endmodule // umsd_target_model

// [tb/unified_memory_space_decoder_tb_top.sv]
`timescale 1ns/1ns
module unified_memory_space_decoder_tb_top import umsd_pkg::*;;
    logic mclk = 0, reset = 1, fetch_req = 0, xd_req = 0, xd_wr = 0, dma_req = 0, dma_wr = 0;
    logic [15:0] fetch_addr = '0, xd_addr = '0, dma_addr = '0;
    logic [7:0] xd_wdata = '0, dma_wdata = '0, dd_addr = '0, tgt_rdata;
    logic dd_req = 0, dd_indirect = 0, dd_bit = 0;
    logic fetch_ack, fetch_stall, xd_ack, dma_ack, tgt_wr, tgt_nonret, tgt_unmapped;
    logic dd_ack, dd_idata_sel, dd_sfr_sel, dd_sfr_bitok, dd_refused;
    logic [7:0] fetch_rdata, xd_rdata, dma_rdata, tgt_wdata, dd_index, cap_rd, cap_wd;
    logic [TGT_COUNT-1:0] tgt_sel, cap_sel;
    logic [15:0] tgt_offset, cap_off;
    logic [SFR_ADDR_W-1:0] tgt_sfr_addr, cap_sa;
    logic cap_unm, cap_nr, cap_wr;
    int err_total = 0, compares = 0, cap_n, cap_first, cap_ack;

    umsd_decoder #(.FLASH_KB(FLASH_KB_32), .HAS_USB(1'b1), .CORE_SFR_MASK(CORE_SFR_MASK_DEFAULT)) uut (
        .mclk(mclk), .reset(reset), .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
        .fetch_rdata(fetch_rdata), .fetch_stall(fetch_stall), .xd_req(xd_req), .xd_addr(xd_addr), .xd_wr(xd_wr),
        .xd_wdata(xd_wdata), .xd_ack(xd_ack), .xd_rdata(xd_rdata), .dma_req(dma_req), .dma_addr(dma_addr),
        .dma_wr(dma_wr), .dma_wdata(dma_wdata), .dma_ack(dma_ack), .dma_rdata(dma_rdata), .tgt_sel(tgt_sel),
        .tgt_offset(tgt_offset), .tgt_sfr_addr(tgt_sfr_addr), .tgt_wr(tgt_wr), .tgt_wdata(tgt_wdata),
        .tgt_rdata(tgt_rdata), .tgt_nonret(tgt_nonret), .tgt_unmapped(tgt_unmapped), .dd_req(dd_req),
        .dd_addr(dd_addr), .dd_indirect(dd_indirect), .dd_bit(dd_bit), .dd_ack(dd_ack), .dd_idata_sel(dd_idata_sel),
        .dd_sfr_sel(dd_sfr_sel), .dd_sfr_bitok(dd_sfr_bitok), .dd_refused(dd_refused), .dd_index(dd_index));
    umsd_target_model far (.mclk(mclk), .tgt_sel(tgt_sel), .tgt_offset(tgt_offset), .tgt_rdata(tgt_rdata));

    always #2 mclk = ~mclk;

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic finish_test();
        if (err_total == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // m: 0 fetch, 1 xdata, 2 dma; request held until its ack
    task automatic op(input int m, input logic [15:0] a, input logic w, input logic [7:0] d);
        cap_n = 0;
        cap_ack = 0;
        cap_first = 0;
        case (m)
            0: {fetch_req, fetch_addr} = {1'b1, a};
            1: {xd_req, xd_addr, xd_wr, xd_wdata} = {1'b1, a, w, d};
            default: {dma_req, dma_addr, dma_wr, dma_wdata} = {1'b1, a, w, d};
        endcase
        for (int n = 1; n < 20 && cap_ack == 0; n++) begin
            @(posedge mclk) #1;
            if (tgt_sel != '0 || tgt_unmapped) begin
                if (cap_n == 0) begin
                    {cap_sel, cap_off, cap_unm, cap_nr, cap_wr, cap_wd, cap_sa} =
                        {tgt_sel, tgt_offset, tgt_unmapped, tgt_nonret, tgt_wr, tgt_wdata, tgt_sfr_addr};
                    cap_first = n;
                end
                cap_n++;
            end
            if (fetch_ack || xd_ack || dma_ack) begin
                cap_ack = n;
                cap_rd = (m == 0) ? fetch_rdata : (m == 1) ? xd_rdata : dma_rdata;
            end
        end
        {fetch_req, xd_req, dma_req} = 3'h0;
        @(posedge mclk) #1;
    endtask

    task automatic t_map(input logic [15:0] a, input logic [6:0] s, input logic [15:0] o);
        for (int m = 0; m < 3; m++) begin
            op(m, a, 1'b0, 8'h00);
            chk("select", cap_sel, s);
            chk("unmapped", cap_unm, s == '0);
            chk("register address", cap_sa, a[6:0]);
            if (s != '0) begin
                chk("offset", cap_off, o);
                chk("read data", cap_rd, o[7:0] ^ 8'hA5);
            end
            chk("ack delay", cap_ack - cap_first, (m == 1) ? 4 : 1);
            chk("select cycles", cap_n, (m == 1) ? 4 : 1);
        end
    endtask

    task automatic t_write();
        op(1, 16'h0010, 1'b1, 8'h3C);
        chk("flash write", {cap_sel, cap_unm, cap_wr}, 9'h002);
        op(2, 16'hFDA2, 1'b1, 8'hC3);
        chk("sram write", {cap_sel, cap_wr, cap_wd}, 16'h05C3);
        chk("lost in deep sleep", cap_nr, 1'b1);
        op(0, 16'hFDA1, 1'b0, 8'h00);
        chk("retained", cap_nr, 1'b0);
    endtask

    task automatic t_stall();
        int stall_n;
        stall_n = 0;
        {fetch_req, fetch_addr, xd_req, xd_addr, xd_wr} = {1'b1, 16'hF000, 1'b1, 16'hDF00, 1'b0};
        for (int n = 0; n < 20 && xd_ack !== 1'b1; n++) begin
            @(posedge mclk) #1;
            stall_n += fetch_stall;
            chk("fetch during xdata", fetch_ack, 1'b0);
        end
        chk("xdata done", xd_ack, 1'b1);
        chk("stall cycles", stall_n, 4);
        xd_req = 0;
        for (int n = 0; n < 20 && fetch_ack !== 1'b1; n++) @(posedge mclk) #1;
        chk("fetch after", fetch_ack, 1'b1);
        fetch_req = 0;
        @(posedge mclk) #1;
    endtask

    // e/k order: ack, idata, sfr, bit ok, refused
    task automatic t_dd(input logic [7:0] a, input logic ind, input logic b, input logic [4:0] e, input logic [4:0] k);
        {dd_req, dd_addr, dd_indirect, dd_bit} = {1'b1, a, ind, b};
        for (int n = 0; n < 4 && dd_ack !== 1'b1; n++) @(posedge mclk) #1;
        chk("direct flags", {dd_ack, dd_idata_sel, dd_sfr_sel, dd_sfr_bitok, dd_refused} & k, e);
        chk("direct index", dd_index, a);
        dd_req = 0;
        @(posedge mclk) #1;
    endtask

    initial begin
        #20000;
        err_total++;
        finish_test();
    end

    initial begin
        repeat (3) @(posedge mclk);
        #1 reset = 0;
        t_map(16'h0000, 7'h01, 16'h0000);
        t_map(16'h7FFF, 7'h01, 16'h7FFF);
        t_map(16'h8000, 7'h00, 16'h0000);
        t_map(16'hF000, 7'h02, 16'h0000);
        t_map(16'hFEFF, 7'h02, 16'h0EFF);
        t_map(16'hFF80, 7'h04, 16'h0080);
        t_map(16'hDF3D, 7'h08, 16'h003D);
        t_map(16'hDF3E, 7'h00, 16'h0000);
        t_map(16'hDF48, 7'h10, 16'h0008);
        t_map(16'hDF90, 7'h20, 16'h0010);
        t_map(16'hDF81, 7'h00, 16'h0000);
        t_map(16'hDE3F, 7'h40, 16'h003F);
        t_map(16'hDE40, 7'h00, 16'h0000);
        t_write();
        t_stall();
        t_dd(8'h7F, 1'b0, 1'b0, 5'h18, 5'h1F);
        t_dd(8'h90, 1'b0, 1'b0, 5'h16, 5'h1E);
        t_dd(8'h90, 1'b1, 1'b0, 5'h18, 5'h1E);
        t_dd(8'h88, 1'b0, 1'b1, 5'h12, 5'h13);
        t_dd(8'h89, 1'b0, 1'b1, 5'h11, 5'h13);
        finish_test();
    end
endmodule // unified_memory_space_decoder_tb_top
